// ### input_undervoltage_fault_handler.sv
`timescale 1ns/1ps
`default_nettype none
module input_undervoltage_fault_handler
   import uv_fault_pkg::*;
#(
   parameter int base_cycles = uv_fault_pkg::unit_base_cycles
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic wr_en,
   input wire logic [7:0] wr_code,
   input wire logic [15:0] wr_data,
   input wire logic [7:0] rd_code,
   input wire logic [15:0] vin_sample,
   input wire logic vin_valid,
   input wire logic output_cmd_on,
   input wire logic status_bit_clear,
   input wire logic other_fault,
   output logic [15:0] rd_data,
   output logic output_enable,
   output logic fault_flag,
   output logic fault_latched,
   output logic restart_pulse
);
   import uv_fault_pkg::*;

   // ****************************************
   // Register file
   // ****************************************
   logic [15:0] input_low_trip_level;
   logic [7:0] input_low_reaction_config;
   logic [15:0] delay_unit_len;
   logic [15:0] next_input_low_trip_level;
   logic [7:0] next_input_low_reaction_config;
   logic [15:0] next_delay_unit_len;
   logic [15:0] next_rd_data;
   logic clear_cmd;

   // Writes, reads and clear command decode
   always_comb begin
      next_input_low_trip_level = input_low_trip_level;
      next_input_low_reaction_config = input_low_reaction_config;
      next_delay_unit_len = delay_unit_len;
      clear_cmd = wr_en && (wr_code == clear_faults_code);
      if (wr_en) begin
         case (wr_code)
            trip_level_code: next_input_low_trip_level = wr_data;
            reaction_config_code: begin
               next_input_low_reaction_config = wr_data[7:0];
            end
            delay_unit_code: next_delay_unit_len = wr_data;
            default: ;
         endcase
      end
      case (rd_code)
         trip_level_code: next_rd_data = input_low_trip_level;
         reaction_config_code: begin
            next_rd_data = {8'h00, input_low_reaction_config};
         end
         delay_unit_code: next_rd_data = delay_unit_len;
         default: next_rd_data = 16'h0000;
      endcase
   end

   // Register the register file
   always_ff @(posedge clock) begin
      if (rst) begin
         input_low_trip_level <= trip_level_reset;
         input_low_reaction_config <= reaction_config_reset;
         delay_unit_len <= delay_unit_reset;
         rd_data <= 16'h0000;
      end else begin
         input_low_trip_level <= next_input_low_trip_level;
         input_low_reaction_config <= next_input_low_reaction_config;
         delay_unit_len <= next_delay_unit_len;
         rd_data <= next_rd_data;
      end
   end

   // ****************************************
   // Fault detection and command edge
   // ****************************************
   logic [1:0] reaction;
   logic [2:0] retry_code;
   logic [2:0] delay_code;
   logic uv_now;
   logic uv_hold;
   logic next_uv_hold;
   logic cmd_on_prev;
   logic cmd_on_edge;
   logic fault_clear;

   // Field split, compare and clearing sources
   always_comb begin
      reaction = input_low_reaction_config[reaction_hi:reaction_lo];
      retry_code = input_low_reaction_config[retry_hi:retry_lo];
      delay_code = input_low_reaction_config[delay_hi:delay_lo];
      next_uv_hold = uv_hold;
      if (vin_valid) begin
         next_uv_hold = (vin_sample < input_low_trip_level);
      end
      uv_now = next_uv_hold;
      cmd_on_edge = output_cmd_on && !cmd_on_prev;
      fault_clear = clear_cmd || status_bit_clear || cmd_on_edge;
   end

   // Register the detector
   always_ff @(posedge clock) begin
      if (rst) begin
         uv_hold <= 1'b0;
         cmd_on_prev <= 1'b0;
      end else begin
         uv_hold <= next_uv_hold;
         cmd_on_prev <= output_cmd_on;
      end
   end

   // ****************************************
   // Response state machine
   // ****************************************
   handler_state_e state;
   handler_state_e next_state;
   logic [2:0] tries;
   logic [2:0] next_tries;
   logic next_output_enable;
   logic next_fault_flag;
   logic next_restart_pulse;
   logic timer_start;
   logic timer_done;
   logic unit_pulse;
   logic timing;

   // After shutdown: retry or latch by retry code
   function automatic logic may_retry(input logic [2:0] code,
                                      input logic [2:0] done);
      may_retry = (code == retry_forever) || (done < code);
   endfunction : may_retry

   // Next state, attempts and outputs
   always_comb begin
      next_state = state;
      next_tries = tries;
      next_fault_flag = fault_flag;
      next_restart_pulse = 1'b0;
      timer_start = 1'b0;
      if (uv_now && reaction != react_ignore) begin
         next_fault_flag = 1'b1;
      end
      case (state)
         st_run: begin
            if (uv_now) begin
               next_tries = 3'h0;
               case (reaction)
                  react_ignore: next_state = st_run;
                  react_delay: begin
                     next_state = st_grace;
                     timer_start = 1'b1;
                  end
                  react_retry: begin
                     if (retry_code == retry_none) begin
                        next_state = st_latched;
                     end else begin
                        next_state = st_wait;
                        timer_start = 1'b1;
                     end
                  end
                  default: next_state = st_latched;
               endcase
            end
         end
         st_grace: begin
            if (timer_done) begin
               if (!uv_now) begin
                  next_state = st_run;
               end else if (retry_code == retry_none) begin
                  next_state = st_latched;
               end else begin
                  next_state = st_wait;
                  timer_start = 1'b1;
               end
            end
         end
         st_wait: begin
            if (other_fault || !output_cmd_on) begin
               next_state = st_latched;
            end else if (timer_done) begin
               next_tries = (tries == 3'h7) ? tries : tries + 3'h1;
               next_restart_pulse = 1'b1;
               if (!uv_now) begin
                  next_state = st_run;
               end else if (may_retry(retry_code, next_tries)) begin
                  timer_start = 1'b1;
               end else begin
                  next_state = st_latched;
               end
            end
         end
         st_latched: begin
            if (fault_clear) begin
               next_state = st_run;
            end
         end
         default: next_state = st_run;
      endcase
      if (fault_clear && !uv_now) begin
         next_fault_flag = 1'b0;
      end
      next_output_enable = output_cmd_on &&
         (next_state == st_run || next_state == st_grace);
   end

   // Register the state machine
   always_ff @(posedge clock) begin
      if (rst) begin
         state <= st_run;
         tries <= 3'h0;
         output_enable <= 1'b0;
         fault_flag <= 1'b0;
         fault_latched <= 1'b0;
         restart_pulse <= 1'b0;
      end else begin
         state <= next_state;
         tries <= next_tries;
         output_enable <= next_output_enable;
         fault_flag <= next_fault_flag;
         fault_latched <= (next_state == st_latched);
         restart_pulse <= next_restart_pulse;
      end
   end

   // Unit divider runs only while a delay is pending
   assign timing = (state == st_grace) || (state == st_wait);

   // ****************************************
   // Delay timing
   // ****************************************
   unit_tick #(.base_cycles(base_cycles)) u_tick (
      .clock(clock),
      .rst(rst),
      .run(timing),
      .unit_len(delay_unit_len),
      .tick(unit_pulse)
   );

   delay_timer u_timer (
      .clock(clock),
      .rst(rst),
      .start(timer_start),
      .tick(unit_pulse),
      .code(delay_code),
      .expired(timer_done)
   );

   // ****************************************
   // Checks
   // ****************************************
   ignore_runs_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_run && reaction == react_ignore && output_cmd_on)
      |=> output_enable)
      else $error("output dropped under ignore reaction");
   retry_off_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_run && uv_now && reaction == react_retry)
      |=> !output_enable)
      else $error("output not disabled on fault");
   latch_off_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_latched) |-> !output_enable)
      else $error("output on while latched");
   clear_run_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_latched && fault_clear) |=> state == st_run)
      else $error("clear did not release latch");
   no_retry_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_run && uv_now && reaction == react_retry &&
       retry_code == retry_none) |=> fault_latched)
      else $error("no retry code did not latch");
   grace_on_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_run && uv_now && reaction == react_delay &&
       output_cmd_on) |=> (state == st_grace && output_enable))
      else $error("delay reaction not keeping output on");
   detect_a: assert property (@(posedge clock) disable iff (rst)
      (vin_valid && vin_sample < input_low_trip_level &&
       reaction != react_ignore) |=> fault_flag)
      else $error("fault not flagged");
   tries_cap_a: assert property (@(posedge clock) disable iff (rst)
      (state == st_wait && retry_code != retry_forever)
      |-> tries < retry_code)
      else $error("too many restart attempts");
   level_rd_a: assert property (@(posedge clock) disable iff (rst)
      (wr_en && wr_code == trip_level_code) ##1 (rd_code == trip_level_code)
      |=> rd_data == $past(wr_data, 2))
      else $error("trip level readback wrong");
endmodule : input_undervoltage_fault_handler
`default_nettype wire

// ### uv_fault_pkg.sv
`default_nettype none
package uv_fault_pkg;
   // ****************************************
   // Command codes of the register port
   // ****************************************
   localparam logic [7:0] trip_level_code = 8'h59;
   localparam logic [7:0] reaction_config_code = 8'h5A;
   localparam logic [7:0] delay_unit_code = 8'hC8;
   localparam logic [7:0] clear_faults_code = 8'h03;

   // ****************************************
   // Field positions of the reaction configuration
   // ****************************************
   localparam int reaction_hi = 7;
   localparam int reaction_lo = 6;
   localparam int retry_hi = 5;
   localparam int retry_lo = 3;
   localparam int delay_hi = 2;
   localparam int delay_lo = 0;

   // ****************************************
   // Reaction and retry codes
   // ****************************************
   localparam logic [1:0] react_ignore = 2'h0;
   localparam logic [1:0] react_delay = 2'h1;
   localparam logic [1:0] react_retry = 2'h2;
   localparam logic [1:0] react_latch = 2'h3;
   localparam logic [2:0] retry_none = 3'h0;
   localparam logic [2:0] retry_forever = 3'h7;

   // ****************************************
   // Values after reset
   // ****************************************
   localparam logic [15:0] trip_level_reset = 16'h0000;
   localparam logic [7:0] reaction_config_reset = 8'h80;
   localparam logic [15:0] delay_unit_reset = 16'h0001;

   // ****************************************
   // Time unit base: one delay unit step in clock cycles
   // ****************************************
   localparam int clock_mhz = 10;
   localparam int unit_base_us = 1;
   localparam int unit_base_cycles = (unit_base_us * clock_mhz < 1) ? 1 :
      unit_base_us * clock_mhz;

   // Response states, Gray coded along the usual path
   typedef enum logic [2:0] {
      st_run = 3'h0,
      st_grace = 3'h1,
      st_wait = 3'h3,
      st_latched = 3'h2
   } handler_state_e;
endpackage : uv_fault_pkg
`default_nettype wire

// ### unit_tick.sv
`timescale 1ns/1ps
`default_nettype none
module unit_tick #(
   parameter int base_cycles = 10
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic run,
   input wire logic [15:0] unit_len,
   output logic tick
);
   logic [15:0] base_cnt;
   logic [15:0] next_base_cnt;
   logic [15:0] unit_cnt;
   logic [15:0] next_unit_cnt;
   logic next_tick;
   logic base_end;
   logic unit_end;

   // ****************************************
   // Two stage divider: base step, then unit length
   // ****************************************
   always_comb begin
      base_end = (base_cnt == 16'(base_cycles - 1));
      unit_end = (unit_cnt + 16'h0001 >= unit_len);
      next_base_cnt = base_cnt;
      next_unit_cnt = unit_cnt;
      next_tick = 1'b0;
      if (!run) begin
         next_base_cnt = 16'h0000;
         next_unit_cnt = 16'h0000;
      end else if (base_end) begin
         next_base_cnt = 16'h0000;
         if (unit_end) begin
            next_unit_cnt = 16'h0000;
            next_tick = 1'b1;
         end else begin
            next_unit_cnt = unit_cnt + 16'h0001;
         end
      end else begin
         next_base_cnt = base_cnt + 16'h0001;
      end
   end

   // Register the divider
   always_ff @(posedge clock) begin
      if (rst) begin
         base_cnt <= 16'h0000;
         unit_cnt <= 16'h0000;
         tick <= 1'b0;
      end else begin
         base_cnt <= next_base_cnt;
         unit_cnt <= next_unit_cnt;
         tick <= next_tick;
      end
   end
endmodule : unit_tick
`default_nettype wire

// ### delay_timer.sv
`timescale 1ns/1ps
`default_nettype none
module delay_timer (
   input wire logic clock,
   input wire logic rst,
   input wire logic start,
   input wire logic tick,
   input wire logic [2:0] code,
   output logic expired
);
   logic [7:0] remain;
   logic [7:0] next_remain;
   logic busy;
   logic next_busy;
   logic next_expired;

   // Power of two unit count from a 3-bit code
   function automatic logic [7:0] units_of(input logic [2:0] c);
      units_of = 8'h01 << c;
   endfunction : units_of

   // ****************************************
   // Counts units down; one pulse at the end
   // ****************************************
   always_comb begin
      next_remain = remain;
      next_busy = busy;
      next_expired = 1'b0;
      if (start) begin
         next_remain = units_of(code);
         next_busy = 1'b1;
      end else if (busy && tick) begin
         if (remain == 8'h01) begin
            next_busy = 1'b0;
            next_expired = 1'b1;
         end
         next_remain = remain - 8'h01;
      end
   end

   // Register the timer
   always_ff @(posedge clock) begin
      if (rst) begin
         remain <= 8'h00;
         busy <= 1'b0;
         expired <= 1'b0;
      end else begin
         remain <= next_remain;
         busy <= next_busy;
         expired <= next_expired;
      end
   end
endmodule : delay_timer
`default_nettype wire

// ### uv_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module uv_host_model (
   input wire logic clock,
   input wire logic [15:0] rd_data,
   output logic wr_en,
   output logic [7:0] wr_code,
   output logic [15:0] wr_data,
   output logic [7:0] rd_code,
   output logic output_cmd_on,
   output logic status_bit_clear
);
   import uv_fault_pkg::*;
   // Idle values at time zero
   initial begin
      wr_en = 1'b0;
      wr_code = 8'hFF;
      wr_data = 16'hFFFF;
      rd_code = 8'h00;
      output_cmd_on = 1'b0;
      status_bit_clear = 1'b0;
   end
   // One-cycle write; released lines show the inverse
   task automatic write_reg(input logic [7:0] code, input logic [15:0] data);
      @(posedge clock);
      wr_en <= 1'b1;
      wr_code <= code;
      wr_data <= data;
      @(posedge clock);
      wr_en <= 1'b0;
      wr_code <= ~code;
      wr_data <= ~data;
   endtask : write_reg
   // Read data is valid one cycle after the code
   task automatic read_reg(input logic [7:0] code, output logic [15:0] data);
      @(posedge clock);
      rd_code <= code;
      @(posedge clock);
      @(posedge clock);
      #1 data = rd_data;
   endtask : read_reg
   // Clear by command, by status bit, or by off then on
   task automatic clear_fault(input int how);
      if (how == 0) begin
         write_reg(clear_faults_code, 16'h0000);
      end else if (how == 1) begin
         @(posedge clock);
         status_bit_clear <= 1'b1;
         @(posedge clock);
         status_bit_clear <= 1'b0;
      end else begin
         @(posedge clock);
         output_cmd_on <= 1'b0;
         repeat (3) @(posedge clock);
         output_cmd_on <= 1'b1;
      end
   endtask : clear_fault
   // Level command for the output
   task automatic set_output(input logic on);
      @(posedge clock);
      output_cmd_on <= on;
   endtask : set_output
endmodule : uv_host_model
`default_nettype wire

// ### input_undervoltage_fault_handler_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module input_undervoltage_fault_handler_tb_top;
   import uv_fault_pkg::*;
   logic clock, rst, wr_en, vin_valid, output_cmd_on, status_bit_clear;
   logic other_fault, output_enable, fault_flag, fault_latched, restart_pulse;
   logic [7:0] wr_code, rd_code;
   logic [15:0] wr_data, vin_sample, rd_data, v;
   int num_errors, n_tests, cnt, gap2, gap3;
   // ****************************************
   // Clock, design and host
   // ****************************************
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   input_undervoltage_fault_handler #(.base_cycles(1))
      input_undervoltage_fault_handler_i (
      .clock(clock), .rst(rst), .wr_en(wr_en), .wr_code(wr_code),
      .wr_data(wr_data), .rd_code(rd_code), .vin_sample(vin_sample),
      .vin_valid(vin_valid), .output_cmd_on(output_cmd_on),
      .status_bit_clear(status_bit_clear), .other_fault(other_fault),
      .rd_data(rd_data), .output_enable(output_enable),
      .fault_flag(fault_flag), .fault_latched(fault_latched),
      .restart_pulse(restart_pulse));
   uv_host_model uv_host_model_i (
      .clock(clock), .rd_data(rd_data), .wr_en(wr_en), .wr_code(wr_code),
      .wr_data(wr_data), .rd_code(rd_code), .output_cmd_on(output_cmd_on),
      .status_bit_clear(status_bit_clear));
   // ****************************************
   // Helpers
   // ****************************************
   task automatic check(input string name, input logic [15:0] seen,
                        input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task automatic expect_reg(input logic [7:0] code, input logic [15:0] exp);
      uv_host_model_i.read_reg(code, v);
      check("rd_data", v, exp);
   endtask : expect_reg
   // Input below 0x1000 when low is set
   task automatic set_low(input logic low);
      @(posedge clock);
      vin_sample <= low ? 16'h0800 : 16'h2000;
   endtask : set_low
   // Counts restart pulses until the handler latches off
   task automatic count_to_latch(output int n);
      n = 0;
      for (int i = 0; i < 3000 && fault_latched !== 1'b1; i++) begin
         @(posedge clock);
         #1 if (restart_pulse === 1'b1) n++;
      end
   endtask : count_to_latch
   // Cycles from one restart pulse to the next
   task automatic restart_gap(output int g);
      g = 0;
      for (int i = 0; i < 3000 && restart_pulse !== 1'b1; i++) begin
         @(posedge clock);
         #1;
      end
      @(posedge clock);
      #1;
      for (int i = 0; i < 3000 && restart_pulse !== 1'b1; i++) begin
         @(posedge clock);
         g++;
      end
   endtask : restart_gap
   task automatic recover(input int how);
      set_low(1'b0);
      repeat (3) @(posedge clock);
      uv_host_model_i.clear_fault(how);
      repeat (8) @(posedge clock);
      #1 check("output_enable", output_enable, 1);
      check("fault_latched", fault_latched, 0);
      check("fault_flag", fault_flag, 0);
   endtask : recover
   task automatic wrap_up;
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #5000000;
      num_errors++;
      wrap_up();
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      rst = 1'b1;
      vin_sample = 16'h2000;
      vin_valid = 1'b1;
      other_fault = 1'b0;
      num_errors = 0;
      n_tests = 0;
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      #1 check("output_enable", output_enable, 0);
      check("fault_flag", fault_flag, 0);
      check("fault_latched", fault_latched, 0);
      expect_reg(trip_level_code, 16'h0000);
      expect_reg(reaction_config_code, 16'h0080);
      expect_reg(delay_unit_code, 16'h0001);
      expect_reg(8'h00, 16'h0000);
      uv_host_model_i.write_reg(trip_level_code, 16'hA5C3);
      uv_host_model_i.write_reg(8'h55, 16'h1234);
      expect_reg(trip_level_code, 16'hA5C3);
      uv_host_model_i.write_reg(trip_level_code, 16'h1000);
      uv_host_model_i.write_reg(delay_unit_code, 16'h0002);
      expect_reg(delay_unit_code, 16'h0002);
      uv_host_model_i.set_output(1'b1);
      // Ignore: output keeps running, no flag
      uv_host_model_i.write_reg(reaction_config_code, 16'h0000);
      expect_reg(reaction_config_code, 16'h0000);
      set_low(1'b1);
      repeat (40) @(posedge clock);
      #1 check("output_enable", output_enable, 1);
      check("fault_flag", fault_flag, 0);
      set_low(1'b0);
      // Disable, no retry; then latch mode with each clear
      for (int k = 0; k < 4; k++) begin
         uv_host_model_i.write_reg(reaction_config_code,
                                   k == 0 ? 16'h0080 : 16'h00C0);
         set_low(1'b1);
         repeat (3) @(posedge clock);
         #1 check("output_enable", output_enable, 0);
         check("fault_flag", fault_flag, 1);
         count_to_latch(cnt);
         check("restarts", 16'(cnt), 0);
         check("output_enable", output_enable, 0);
         recover(k % 3);
      end
      // Retry one to six times, then stay off
      for (int n = 1; n <= 6; n++) begin
         uv_host_model_i.write_reg(reaction_config_code, 16'(8'h80 | n << 3));
         set_low(1'b1);
         count_to_latch(cnt);
         check("restarts", 16'(cnt), 16'(n));
         check("output_enable", output_enable, 0);
         recover(n % 3);
      end
      // Gap grows by four units from delay code 2 to 3
      uv_host_model_i.write_reg(reaction_config_code, 16'h00BA);
      set_low(1'b1);
      restart_gap(gap2);
      recover(0);
      uv_host_model_i.write_reg(reaction_config_code, 16'h00BB);
      set_low(1'b1);
      restart_gap(gap3);
      check("gap_step", 16'(gap3 - gap2), 16'h0008);
      check("fault_latched", fault_latched, 0);
      @(posedge clock);
      other_fault <= 1'b1;
      repeat (600) @(posedge clock);
      #1 check("fault_latched", fault_latched, 1);
      other_fault <= 1'b0;
      recover(0);
      // Keep running for eight units, then follow retry none
      uv_host_model_i.write_reg(reaction_config_code, 16'h0043);
      set_low(1'b1);
      cnt = 0;
      for (int i = 0; i < 200 && output_enable === 1'b1; i++) begin
         @(posedge clock);
         #1 cnt++;
      end
      check("grace_ok", 16'(cnt >= 16 && cnt <= 20), 1);
      count_to_latch(gap2);
      check("fault_latched", fault_latched, 1);
      recover(2);
      // Held compare without a new sample, then delay and one retry
      uv_host_model_i.write_reg(reaction_config_code, 16'h0048);
      @(posedge clock);
      vin_valid <= 1'b0;
      set_low(1'b1);
      repeat (20) @(posedge clock);
      #1 check("output_enable", output_enable, 1);
      check("fault_flag", fault_flag, 0);
      @(posedge clock);
      vin_valid <= 1'b1;
      count_to_latch(cnt);
      check("restarts", 16'(cnt), 16'h0001);
      check("fault_latched", fault_latched, 1);
      recover(1);
      wrap_up();
   end
endmodule : input_undervoltage_fault_handler_tb_top
`default_nettype wire
